// *** pkg/rxei_consts.vh ***
// offsets, field positions, reset values and timing counts of the receiver status block
// assumes a 20 MHz system clock and 32-bit APB with one register per word
`ifndef RXEI_CONSTS_VH
`define RXEI_CONSTS_VH

// register indices, byte address is four times the index
`define RXEI_IDX_CLK 8'h00
`define RXEI_IDX_FMT 8'h01
`define RXEI_IDX_IO1 8'h03
`define RXEI_IDX_MASK_A 8'h04
`define RXEI_IDX_MASK_B 8'h05
`define RXEI_IDX_STAT0 8'h06
`define RXEI_IDX_CS0 8'h08
`define RXEI_IDX_CS4 8'h0C
`define RXEI_IDX_Q0 8'h19
`define RXEI_IDX_Q9 8'h22

// field positions
`define RXEI_CLK_SRC_LSB 4
`define RXEI_FMT_LSB 4
`define RXEI_HOLD_LSB 6

// status / mask bit positions
`define RXEI_B_PAR 0
`define RXEI_B_NON_AUDIO_FLAG 1
`define RXEI_B_PEM 2
`define RXEI_B_DTS 3
`define RXEI_B_UNLCK 4
`define RXEI_B_CHSTAT_CHANGE_FLAG 5
`define RXEI_B_AUTO 6
`define RXEI_B_SUBQ_CHANGE_FLAG 7

// reset values; a mask bit of one hides the event from the pin
`define RXEI_RST_CLK_SRC 2'h0
`define RXEI_RST_FMT 3'h4
`define RXEI_RST_HOLD 2'h0
`define RXEI_RST_MASK_A 8'hEE
`define RXEI_RST_MASK_B 8'hB5

// clock source code that turns the loop off
`define RXEI_CLK_PLL_OFF 2'h1

// channel status bit positions
`define RXEI_CS_NONAUDIO 1
`define RXEI_CS_EMPH 3

// timing
`define RXEI_NONPCM_FRAMES 12'hFFF
`define RXEI_HOLD_FS 1024
`define RXEI_CLK_HZ 20000000
`define RXEI_BCLK_HZ 2500000
`define RXEI_BCLK_HALF_CYC (`RXEI_CLK_HZ / (2 * `RXEI_BCLK_HZ))

`endif

// *** logic/rxei_link_sync.v ***
// two-stage synchroniser with edge detection for one pin from outside the clock domain
// assumes the pin toggles slower than a quarter of the system clock rate
`timescale 1ns/1ps
module rxei_link_sync (
	// clock and reset
	input wire i_clock,
	input wire i_reset_n,
	// pin side
	input wire i_pin,
	// synchronised side
	output wire o_level,
	output wire o_rise,
	output wire o_fall
);
	reg meta_reg;
	reg sync_reg;
	reg last_reg;

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= i_pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign o_level = sync_reg;
	assign o_rise = sync_reg & ~last_reg;
	assign o_fall = ~sync_reg & last_reg;
endmodule // rxei_link_sync

// *** logic/rxei_irq_hold.v ***
// interrupt pin driver with a hold time counted in sample periods
// assumes i_fs_tick pulses once per audio frame
`timescale 1ns/1ps
module rxei_irq_hold (
	// clock and reset
	input wire i_clock,
	input wire i_reset_n,
	// control
	input wire i_event,
	input wire i_fs_tick,
	input wire i_force_low,
	input wire [12:0] i_hold_len,
	// pin
	output wire o_irq
);
	reg irq_reg;
	reg [12:0] cnt_reg;

	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_reg <= 1'b0;
			cnt_reg <= 13'h0000;
		end else if (i_force_low) begin
			irq_reg <= 1'b0;
			cnt_reg <= 13'h0000;
		end else if (i_event) begin
			// an event inside the hold window restarts the count
			irq_reg <= 1'b1;
			cnt_reg <= i_hold_len;
		end else if (irq_reg && i_fs_tick) begin
			if (cnt_reg <= 13'h0001)
				irq_reg <= 1'b0;
			cnt_reg <= (cnt_reg == 13'h0000) ? 13'h0000 : cnt_reg - 13'h0001;
		end
	end

	assign o_irq = irq_reg;
endmodule // rxei_irq_hold

// *** logic/rxei_top.v ***
// receiver status flags, interrupt pins and serial audio output port
// assumes receiver core strobes on i_clock; audio port pins are asynchronous
// Operation
// - unlock flag follows loss of loop lock
// - coding error flag sticky until status read
// - non-PCM flag re-evaluated every 4096 frames
// - compressed-CD flag evaluated per its sync
// - non-audio and emphasis mirror channel status
// - subcode change flag sticky until read
// - channel status change flag sticky until read
// - PLL-off clock source forces both pins low
// - pin A holds for programmable sample periods
// - pin B falls as soon as events clear
// - per-pin masks gate eight events, flags untouched
// - reset masks: A lock/coding, B stream flags
// - parallel mode fixes unmasked pin combinations
// - captured status kept while lock lost
// - repeat last good sub-frame on error
// - zeros when unlocked unless auxiliary input used
// - MSB first, launch falling, sample rising
// - format code selects eight serial layouts
// - master formats drive clocks; slave formats receive
// - short formats truncate low bits
// - auxiliary input left-justified or I2S, mode gated
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rxei_consts.vh"
module rxei_top #(
	parameter HOLD_BASE = `RXEI_HOLD_FS
) (
	// clock and reset
	input wire i_clock,
	input wire i_reset_n,
	// apb slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	// receiver core events
	input wire i_lock_lost,
	input wire i_subframe_strobe,
	input wire i_coding_err,
	input wire i_frame_strobe,
	input wire i_nonpcm_hit,
	input wire i_ccd_sync,
	input wire i_ccd_hit,
	input wire i_cs_strobe,
	input wire [39:0] i_cs_bits,
	input wire i_subq_strobe,
	input wire [79:0] i_subq_bits,
	// received samples
	input wire i_sample_strobe,
	input wire i_sample_err,
	input wire [23:0] i_sample_left,
	input wire [23:0] i_sample_right,
	// mode pin
	input wire i_parallel_mode,
	// audio serial port
	input wire i_bit_clock,
	output wire o_bit_clock,
	output wire o_bit_clock_oe,
	input wire i_word_clock,
	output wire o_word_clock,
	output wire o_word_clock_oe,
	input wire i_aux_serial_in,
	output wire o_serial_audio_out,
	// interrupt pins
	output wire o_irq_pin_a,
	output wire o_irq_pin_b
);
	reg [1:0] clk_src_reg;
	reg [2:0] fmt_reg;
	reg [1:0] hold_sel_reg;
	reg [7:0] mask_a_reg;
	reg [7:0] mask_b_reg;
	reg coding_error_flag_reg;
	reg nonpcm_detect_flag_reg;
	reg nonpcm_seen_reg;
	reg [11:0] frame_cnt_reg;
	reg compressed_cd_flag_reg;
	reg non_audio_flag_reg;
	reg emphasis_flag_reg;
	reg subq_change_flag_reg;
	reg chstat_change_flag_reg;
	reg [39:0] cs_reg;
	reg [79:0] subq_reg;
	reg [23:0] held_left_reg;
	reg [23:0] held_right_reg;
	reg [31:0] prdata_reg;
	reg pslverr_reg;
	reg par_meta_reg;
	reg par_sync_reg;
	reg aux_meta_reg;
	reg aux_sync_reg;
	wire [7:0] idx = i_paddr[9:2];
	wire apb_acc = i_psel & i_penable;
	wire apb_wr = apb_acc & i_pwrite;
	wire rd_stat = apb_acc & ~i_pwrite & (idx == `RXEI_IDX_STAT0);

	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `RXEI_IDX_CLK) || (a == `RXEI_IDX_FMT) || (a == `RXEI_IDX_IO1) ||
				(a == `RXEI_IDX_MASK_A) || (a == `RXEI_IDX_MASK_B) ||
				(a == `RXEI_IDX_STAT0) ||
				(a >= `RXEI_IDX_CS0 && a <= `RXEI_IDX_CS4) ||
				(a >= `RXEI_IDX_Q0 && a <= `RXEI_IDX_Q9);
		end
	endfunction
	// control registers
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clk_src_reg <= `RXEI_RST_CLK_SRC;
			fmt_reg <= `RXEI_RST_FMT;
			hold_sel_reg <= `RXEI_RST_HOLD;
			mask_a_reg <= `RXEI_RST_MASK_A;
			mask_b_reg <= `RXEI_RST_MASK_B;
		end else if (apb_wr) begin
			case (idx)
				`RXEI_IDX_CLK: clk_src_reg <= i_pwdata[`RXEI_CLK_SRC_LSB+1:`RXEI_CLK_SRC_LSB];
				`RXEI_IDX_FMT: fmt_reg <= i_pwdata[`RXEI_FMT_LSB+2:`RXEI_FMT_LSB];
				`RXEI_IDX_IO1: hold_sel_reg <= i_pwdata[`RXEI_HOLD_LSB+1:`RXEI_HOLD_LSB];
				`RXEI_IDX_MASK_A: mask_a_reg <= i_pwdata[7:0];
				`RXEI_IDX_MASK_B: mask_b_reg <= i_pwdata[7:0];
				default: clk_src_reg <= clk_src_reg;
			endcase
		end
	end

	// event flags; a set in the cycle of the clearing read wins
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			coding_error_flag_reg <= 1'b0;
			nonpcm_detect_flag_reg <= 1'b0;
			nonpcm_seen_reg <= 1'b0;
			frame_cnt_reg <= 12'h000;
			compressed_cd_flag_reg <= 1'b0;
			non_audio_flag_reg <= 1'b0;
			emphasis_flag_reg <= 1'b0;
			subq_change_flag_reg <= 1'b0;
			chstat_change_flag_reg <= 1'b0;
			cs_reg <= 40'h00_0000_0000;
			subq_reg <= 80'h0000_0000_0000_0000_0000;
		end else begin
			if (i_subframe_strobe && i_coding_err)
				coding_error_flag_reg <= 1'b1;
			else if (rd_stat)
				coding_error_flag_reg <= 1'b0;
			if (i_frame_strobe) begin
				frame_cnt_reg <= frame_cnt_reg + 12'h001;
				if (frame_cnt_reg == `RXEI_NONPCM_FRAMES) begin
					nonpcm_detect_flag_reg <= nonpcm_seen_reg | i_nonpcm_hit;
					nonpcm_seen_reg <= 1'b0;
				end else if (i_nonpcm_hit)
					nonpcm_seen_reg <= 1'b1;
			end
			if (i_ccd_sync)
				compressed_cd_flag_reg <= i_ccd_hit;
			if (i_cs_strobe && !i_lock_lost) begin
				cs_reg <= i_cs_bits;
				non_audio_flag_reg <= i_cs_bits[`RXEI_CS_NONAUDIO];
				emphasis_flag_reg <= i_cs_bits[`RXEI_CS_EMPH];
			end
			if (i_cs_strobe && !i_lock_lost && (i_cs_bits != cs_reg))
				chstat_change_flag_reg <= 1'b1;
			else if (rd_stat)
				chstat_change_flag_reg <= 1'b0;
			if (i_subq_strobe && !i_lock_lost)
				subq_reg <= i_subq_bits;
			if (i_subq_strobe && !i_lock_lost && (i_subq_bits != subq_reg))
				subq_change_flag_reg <= 1'b1;
			else if (rd_stat)
				subq_change_flag_reg <= 1'b0;
		end
	end
	wire [7:0] status = {subq_change_flag_reg, nonpcm_detect_flag_reg, chstat_change_flag_reg,
		i_lock_lost, compressed_cd_flag_reg, emphasis_flag_reg, non_audio_flag_reg,
		coding_error_flag_reg};
	// apb read data, zero wait states
	always @* begin
		prdata_reg = 32'h0000_0000;
		pslverr_reg = 1'b0;
		if (i_psel && !mapped(idx))
			pslverr_reg = 1'b1;
		else if (idx >= `RXEI_IDX_CS0 && idx <= `RXEI_IDX_CS4)
			prdata_reg[7:0] = cs_reg[{idx[2:0], 3'h0} +: 8];
		else if (idx >= `RXEI_IDX_Q0 && idx <= `RXEI_IDX_Q9)
			prdata_reg[7:0] = subq_reg[{idx[3:0] - 4'h9, 3'h0} +: 8];
		else begin
			case (idx)
				`RXEI_IDX_CLK: prdata_reg[`RXEI_CLK_SRC_LSB+1:`RXEI_CLK_SRC_LSB] = clk_src_reg;
				`RXEI_IDX_FMT: prdata_reg[`RXEI_FMT_LSB+2:`RXEI_FMT_LSB] = fmt_reg;
				`RXEI_IDX_IO1: prdata_reg[`RXEI_HOLD_LSB+1:`RXEI_HOLD_LSB] = hold_sel_reg;
				`RXEI_IDX_MASK_A: prdata_reg[7:0] = mask_a_reg;
				`RXEI_IDX_MASK_B: prdata_reg[7:0] = mask_b_reg;
				`RXEI_IDX_STAT0: prdata_reg[7:0] = status;
				default: prdata_reg = 32'h0000_0000;
			endcase
		end
	end
	assign o_prdata = prdata_reg;
	assign o_pready = 1'b1;
	assign o_pslverr = pslverr_reg;
	// mode pin and auxiliary data pin synchronisers
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			par_meta_reg <= 1'b0;
			par_sync_reg <= 1'b0;
			aux_meta_reg <= 1'b0;
			aux_sync_reg <= 1'b0;
		end else begin
			par_meta_reg <= i_parallel_mode;
			par_sync_reg <= par_meta_reg;
			aux_meta_reg <= i_aux_serial_in;
			aux_sync_reg <= aux_meta_reg;
		end
	end
	// parallel mode uses the reset masks, software masks are ignored
	wire [7:0] eff_mask_a = par_sync_reg ? `RXEI_RST_MASK_A : mask_a_reg;
	wire [7:0] eff_mask_b = par_sync_reg ? `RXEI_RST_MASK_B : mask_b_reg;
	wire pll_off = (clk_src_reg == `RXEI_CLK_PLL_OFF);
	wire event_a = |(status & ~eff_mask_a);
	wire event_b = |(status & ~eff_mask_b);
	wire [12:0] hold_len = (hold_sel_reg == 2'h0) ? HOLD_BASE[12:0] :
		(hold_sel_reg == 2'h1) ? {HOLD_BASE[11:0], 1'b0} :
		(hold_sel_reg == 2'h2) ? {HOLD_BASE[10:0], 2'h0} : {1'b0, HOLD_BASE[12:1]};
	wire fs_tick;
	rxei_irq_hold u_hold_a (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_event(event_a),
		.i_fs_tick(fs_tick),
		.i_force_low(pll_off),
		.i_hold_len(hold_len),
		.o_irq(o_irq_pin_a)
	);
	assign o_irq_pin_b = event_b & ~pll_off;
	// audio serial port
	wire slave = fmt_reg[2] & fmt_reg[1];
	wire i2s = (fmt_reg == 3'h5) || (fmt_reg == 3'h7);
	wire bck_lvl;
	wire bck_rise;
	wire bck_fall;
	wire wck_lvl;
	reg [7:0] div_reg;
	reg bclk_reg;
	reg [5:0] bit_cnt_reg;
	reg wclk_reg;
	reg half_reg;
	reg [31:0] shift_reg;
	reg sdo_reg;
	reg [5:0] rx_cnt_reg;
	reg [23:0] aux_shift_reg;
	reg [23:0] aux_left_reg;
	reg [23:0] aux_right_reg;
	reg rx_half_reg;
	rxei_link_sync u_bck_sync (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_pin(i_bit_clock),
		.o_level(bck_lvl),
		.o_rise(bck_rise),
		.o_fall(bck_fall)
	);
	rxei_link_sync u_wck_sync (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_pin(i_word_clock),
		.o_level(wck_lvl),
		.o_rise(),
		.o_fall()
	);

	wire m_tick = (div_reg == `RXEI_BCLK_HALF_CYC - 1);
	wire fall_ev = slave ? bck_fall : (m_tick & bclk_reg);
	wire rise_ev = slave ? bck_rise : (m_tick & ~bclk_reg);
	wire [5:0] bit_cnt_next = bit_cnt_reg + 6'h01;
	wire wclk_now = slave ? wck_lvl : (bit_cnt_next[5] ^ ~i2s);
	wire right_half = wclk_now ^ ~i2s;
	wire use_aux = (clk_src_reg == 2'h1) || (clk_src_reg == 2'h3) ||
		((clk_src_reg == 2'h2) && i_lock_lost);
	wire [23:0] rx_word = right_half ? held_right_reg : held_left_reg;
	wire [23:0] aux_word = right_half ? aux_right_reg : aux_left_reg;
	wire [23:0] src_word = use_aux ? aux_word : (i_lock_lost ? 24'h00_0000 : rx_word);
	reg [31:0] load_word;

	// 16-, 18- and 20-bit right-justified widths drop the low bits of the sub-frame sample; 24-bit keeps all
	always @* begin
		case (fmt_reg)
			3'h0: load_word = {16'h0000, src_word[23:8]};
			3'h1: load_word = {14'h0000, src_word[23:6]};
			3'h2: load_word = {12'h000, src_word[23:4]};
			3'h3: load_word = {8'h00, src_word};
			3'h5, 3'h7: load_word = {1'b0, src_word, 7'h00};
			default: load_word = {src_word, 8'h00};
		endcase
	end

	// last error-free samples
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			held_left_reg <= 24'h00_0000;
			held_right_reg <= 24'h00_0000;
		end else if (i_sample_strobe && !i_sample_err) begin
			held_left_reg <= i_sample_left;
			held_right_reg <= i_sample_right;
		end
	end

	// master clock generation and output shifter
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_reg <= 8'h00;
			bclk_reg <= 1'b1;
			bit_cnt_reg <= 6'h3F;
			wclk_reg <= 1'b0;
			half_reg <= 1'b0;
			shift_reg <= 32'h0000_0000;
			sdo_reg <= 1'b0;
		end else begin
			div_reg <= m_tick ? 8'h00 : div_reg + 8'h01;
			if (m_tick)
				bclk_reg <= ~bclk_reg;
			if (fall_ev) begin
				bit_cnt_reg <= bit_cnt_next;
				wclk_reg <= wclk_now;
				half_reg <= right_half;
				if (right_half != half_reg) begin
					sdo_reg <= load_word[31];
					shift_reg <= {load_word[30:0], 1'b0};
				end else begin
					sdo_reg <= shift_reg[31];
					shift_reg <= {shift_reg[30:0], 1'b0};
				end
			end
		end
	end
	assign fs_tick = fall_ev & right_half & ~half_reg;
	// auxiliary input capture on rising bit clock; count k marks bit k of the half
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_cnt_reg <= 6'h00;
			rx_half_reg <= 1'b0;
			aux_shift_reg <= 24'h00_0000;
			aux_left_reg <= 24'h00_0000;
			aux_right_reg <= 24'h00_0000;
		end else if (rise_ev) begin
			aux_shift_reg <= {aux_shift_reg[22:0], aux_sync_reg};
			rx_half_reg <= half_reg;
			rx_cnt_reg <= (half_reg != rx_half_reg) ? 6'h01 : rx_cnt_reg + 6'h01;
			if (rx_cnt_reg == (i2s ? 6'h18 : 6'h17)) begin
				if (half_reg)
					aux_right_reg <= {aux_shift_reg[22:0], aux_sync_reg};
				else
					aux_left_reg <= {aux_shift_reg[22:0], aux_sync_reg};
			end
		end
	end

	assign o_bit_clock = bclk_reg;
	assign o_bit_clock_oe = ~slave;
	assign o_word_clock = wclk_reg;
	assign o_word_clock_oe = ~slave;
	assign o_serial_audio_out = sdo_reg;
endmodule // rxei_top

// *** verif/rxei_top_properties.sv ***
// port assertions for the receiver status block
// assumes one clock domain; register writes are snooped on the APB port
`timescale 1ns/1ps
`include "rxei_consts.vh"
module rxei_chk #(
	parameter HOLD_BASE = `RXEI_HOLD_FS
) (
	// clock, reset and bus
	input wire i_clock,
	input wire i_reset_n,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	// events
	input wire i_lock_lost,
	input wire i_subframe_strobe,
	input wire i_coding_err,
	input wire i_parallel_mode,
	// pins
	input wire o_bit_clock,
	input wire o_bit_clock_oe,
	input wire o_word_clock,
	input wire o_word_clock_oe,
	input wire o_serial_audio_out,
	input wire o_irq_pin_a,
	input wire o_irq_pin_b
);
	// shortest hold: half the base, first frame tick may come at once
	localparam int HMIN = (HOLD_BASE / 2 - 1) * 500;
	reg [1:0] src_reg;
	reg [2:0] fmt_reg;
	reg [7:0] ma_reg;
	reg [7:0] mb_reg;
	reg [19:0] hi_reg;
	reg [9:0] ul_reg;
	wire wr = i_psel & i_penable & i_pwrite;
	wire [7:0] ix = i_paddr[9:2];
	wire [7:0] ea = i_parallel_mode ? `RXEI_RST_MASK_A : ma_reg;
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			src_reg <= `RXEI_RST_CLK_SRC;
			fmt_reg <= `RXEI_RST_FMT;
			ma_reg <= `RXEI_RST_MASK_A;
			mb_reg <= `RXEI_RST_MASK_B;
			hi_reg <= 20'h0;
			ul_reg <= 10'h0;
		end else begin
			if (wr && ix == `RXEI_IDX_CLK) src_reg <= i_pwdata[5:4];
			if (wr && ix == `RXEI_IDX_FMT) fmt_reg <= i_pwdata[6:4];
			if (wr && ix == `RXEI_IDX_MASK_A) ma_reg <= i_pwdata[7:0];
			if (wr && ix == `RXEI_IDX_MASK_B) mb_reg <= i_pwdata[7:0];
			hi_reg <= o_irq_pin_a ? hi_reg + 20'h1 : 20'h0;
			ul_reg <= (i_lock_lost && src_reg == 2'h0) ? ul_reg + {9'h0, ~&ul_reg} : 10'h0;
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	chk_pll_off_low: assert property (
		src_reg == 2'h1 && $past(src_reg) == 2'h1 |-> !o_irq_pin_a && !o_irq_pin_b)
		else $error("interrupt pin high with loop off");
	chk_unlock_pin_a: assert property (
		(i_lock_lost && !ea[4] && src_reg != 2'h1)[*4] |-> o_irq_pin_a)
		else $error("pin a low while unlocked");
	chk_coding_pin_a: assert property (
		i_subframe_strobe && i_coding_err && !ea[0] && src_reg != 2'h1 |-> ##[1:3] o_irq_pin_a)
		else $error("pin a missed coding error");
	chk_mask_b_all: assert property (
		!i_parallel_mode && !$past(i_parallel_mode, 3) && mb_reg == 8'hFF
		&& $past(mb_reg) == 8'hFF |-> !o_irq_pin_b)
		else $error("pin b high with all masked");
	chk_hold_min: assert property (
		$fell(o_irq_pin_a) && src_reg != 2'h1 |-> hi_reg >= HMIN)
		else $error("pin a hold too short");
	chk_bclk_half: assert property (
		o_bit_clock_oe && $changed(o_bit_clock)
		|=> ($stable(o_bit_clock) || $changed(fmt_reg))[*3])
		else $error("bit clock half period short");
	chk_sdo_launch: assert property (
		o_bit_clock_oe && $stable(o_bit_clock_oe) && $changed(o_serial_audio_out) |-> !o_bit_clock)
		else $error("data changed while bit clock high");
	chk_wclk_launch: assert property (
		o_word_clock_oe && $stable(o_word_clock_oe) && $changed(o_word_clock) |-> !o_bit_clock)
		else $error("word clock changed while bit clock high");
	chk_port_dir: assert property (
		$stable(fmt_reg) |-> o_bit_clock_oe == (fmt_reg < 3'h6) && o_word_clock_oe == o_bit_clock_oe)
		else $error("clock direction wrong for format");
	chk_unlock_zero: assert property (
		&ul_reg |-> !o_serial_audio_out)
		else $error("data not zero while unlocked");
	cover property ($rose(o_irq_pin_a));
	cover property ($fell(o_irq_pin_a));
	cover property ($rose(o_irq_pin_b));
	cover property ($fell(o_bit_clock_oe));
endmodule // rxei_chk

bind rxei_top rxei_chk #(.HOLD_BASE(HOLD_BASE)) u_chk (.*);

// *** verif/rxei_dsp_model.sv ***
// serial audio receiver model: captures each word clock half, makes slave clocks, feeds aux data
// assumes 32 bit clocks per word clock half
`timescale 1ns/1ps
module rxei_dsp_model (
	// board lines
	input wire i_bit_clock,
	input wire i_word_clock,
	input wire i_serial_audio_out,
	// slave clocks
	input wire i_slave,
	output logic o_bit_clock,
	output logic o_word_clock,
	// auxiliary source
	input wire [23:0] i_aux_word,
	output logic o_aux,
	// last captured halves
	output logic [31:0] o_half_hi,
	output logic [31:0] o_half_lo
);
	logic [31:0] sh = 32'h0;
	logic wp = 1'h0;
	logic [4:0] pos = 5'h1F;
	logic [4:0] gen = 5'h0;
	wire [4:0] nx = pos + 5'h1;
	initial begin
		o_bit_clock = 1'h1;
		o_word_clock = 1'h0;
		o_aux = 1'h0;
		o_half_hi = 32'h0;
		o_half_lo = 32'h0;
	end
	// 400 ns bit clock, word clock turns on a falling edge every 32 bits
	always begin
		#200;
		if (i_slave) begin
			o_bit_clock = ~o_bit_clock;
			gen = o_bit_clock ? gen : gen + 5'h1;
			o_word_clock = (!o_bit_clock && gen == 5'h0) ? ~o_word_clock : o_word_clock;
		end
	end
	always @(posedge i_bit_clock) begin
		sh <= {sh[30:0], i_serial_audio_out};
		wp <= i_word_clock;
		pos <= (i_word_clock != wp) ? 5'h0 : nx;
		if (i_word_clock != wp && wp) o_half_hi <= sh;
		if (i_word_clock != wp && !wp) o_half_lo <= sh;
	end
	// left-justified aux word, settled a half period before the sampling rise
	always @(negedge i_bit_clock) o_aux <= (nx < 5'd24) ? i_aux_word[5'd23 - nx] : 1'h0;
endmodule // rxei_dsp_model

// *** verif/tb_top.sv ***
// self-checking bench for the receiver status block
// assumes a hold base of 4 frames and the audio receiver model on the serial port
`timescale 1ns/1ps
`include "rxei_consts.vh"
module tb_top;
	logic i_clock = 1'h0;
	logic i_reset_n = 1'h0;
	logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, perr, lock = 1'h0, cerr = 1'h0, nph = 1'h0;
	logic sfs = 1'h0, css = 1'h0, sqs = 1'h0, ccs = 1'h0, frs = 1'h0, smp = 1'h0;
	logic cch = 1'h0, serr = 1'h0, par = 1'h0, slave = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic [39:0] csb = 40'h0;
	logic [79:0] sqb = 80'h0;
	logic [23:0] sl = 24'hA5C3F1, sr = 24'h5A3C0F, auxw = 24'h3C96E1;
	wire [31:0] prdata, hi, lo;
	wire pready, pslverr, bco, bcoe, wco, wcoe, sdo, irqa, irqb, bcm, wcm, aux;
	wire bcl = bcoe ? bco : bcm;
	wire wcl = wcoe ? wco : wcm;
	int error_cnt = 0, checked = 0, cyc = 0, i;
	int sft[8] = '{0, 2, 4, 8, 16, 15, 16, 15};
	rxei_top #(.HOLD_BASE(4)) dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_lock_lost(lock), .i_subframe_strobe(sfs),
		.i_coding_err(cerr), .i_frame_strobe(frs), .i_nonpcm_hit(nph), .i_ccd_sync(ccs),
		.i_ccd_hit(cch), .i_cs_strobe(css), .i_cs_bits(csb), .i_subq_strobe(sqs),
		.i_subq_bits(sqb), .i_sample_strobe(smp), .i_sample_err(serr), .i_sample_left(sl),
		.i_sample_right(sr), .i_parallel_mode(par), .i_bit_clock(bcl), .o_bit_clock(bco),
		.o_bit_clock_oe(bcoe), .i_word_clock(wcl), .o_word_clock(wco), .o_word_clock_oe(wcoe),
		.i_aux_serial_in(aux), .o_serial_audio_out(sdo), .o_irq_pin_a(irqa), .o_irq_pin_b(irqb));
	rxei_dsp_model dsp (.i_bit_clock(bcl), .i_word_clock(wcl), .i_serial_audio_out(sdo),
		.i_slave(slave), .o_bit_clock(bcm), .o_word_clock(wcm), .i_aux_word(auxw), .o_aux(aux),
		.o_half_hi(hi), .o_half_lo(lo));
	always #25 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			error_cnt = error_cnt + 1;
			complete_run();
		end
	end
	task complete_run();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("mismatch %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task cpin(input logic got, input logic exp);
		checked = checked + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("mismatch %0t pin %b expected %b", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1'h1;
		pwr <= w;
		paddr <= {2'h0, ix, 2'h0};
		pwdata <= d;
		@(posedge i_clock);
		pen <= 1'h1;
		do begin
			@(posedge i_clock);
		end while (pready !== 1'h1);
		cpin(pready, 1'h1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task rdc(input logic [7:0] ix, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, ix, 32'h0);
		cmp(rd & m, e);
	endtask
	// strobe order: subframe, status block, subcode, compressed sync, frame, sample
	task pulse(input logic [5:0] k);
		@(posedge i_clock);
		{sfs, css, sqs, ccs, frs, smp} <= k;
		@(posedge i_clock);
		{sfs, css, sqs, ccs, frs, smp} <= 6'h0;
	endtask
	initial begin
		repeat (5) @(posedge i_clock);
		i_reset_n <= 1'h1;
		rdc(`RXEI_IDX_FMT, 32'h70, 32'h40);
		rdc(`RXEI_IDX_MASK_A, 32'hFF, 32'hEE);
		rdc(`RXEI_IDX_MASK_B, 32'hFF, 32'hB5);
		rdc(8'h30, 32'hFFFFFFFF, 32'h0);
		cpin(perr, 1'h1);
		cerr <= 1'h1;
		pulse(6'h20);
		cerr <= 1'h0;
		repeat (3) @(posedge i_clock);
		cpin(irqa, 1'h1);
		cpin(irqb, 1'h0);
		rdc(`RXEI_IDX_STAT0, 32'h1, 32'h1);
		rdc(`RXEI_IDX_STAT0, 32'h1, 32'h0);
		repeat (1000) @(posedge i_clock);
		cerr <= 1'h1;
		pulse(6'h20);
		cerr <= 1'h0;
		rdc(`RXEI_IDX_STAT0, 32'h1, 32'h1);
		repeat (1400) @(posedge i_clock);
		cpin(irqa, 1'h1);
		repeat (1600) @(posedge i_clock);
		cpin(irqa, 1'h0);
		csb <= 40'h0A;
		pulse(6'h10);
		@(posedge i_clock);
		cpin(irqb, 1'h1);
		rdc(`RXEI_IDX_STAT0, 32'h26, 32'h26);
		rdc(`RXEI_IDX_STAT0, 32'h20, 32'h0);
		rdc(`RXEI_IDX_CS0, 32'hFF, 32'h0A);
		apb(1'h1, `RXEI_IDX_MASK_B, 32'hFF);
		@(posedge i_clock);
		cpin(irqb, 1'h0);
		rdc(`RXEI_IDX_STAT0, 32'h6, 32'h6);
		apb(1'h1, `RXEI_IDX_MASK_B, 32'hB5);
		csb <= 40'h0;
		pulse(6'h10);
		@(posedge i_clock);
		cpin(irqb, 1'h0);
		sqb <= 80'h1234;
		pulse(6'h08);
		rdc(`RXEI_IDX_Q0, 32'hFF, 32'h34);
		rdc(`RXEI_IDX_STAT0, 32'hA0, 32'hA0);
		rdc(`RXEI_IDX_STAT0, 32'h80, 32'h0);
		pulse(6'h01);
		lock <= 1'h1;
		repeat (4) @(posedge i_clock);
		rdc(`RXEI_IDX_STAT0, 32'h10, 32'h10);
		cpin(irqa, 1'h1);
		csb <= 40'h55;
		sqb <= 80'h99;
		pulse(6'h18);
		rdc(`RXEI_IDX_CS0, 32'hFF, 32'h0);
		rdc(`RXEI_IDX_Q0, 32'hFF, 32'h34);
		rdc(`RXEI_IDX_STAT0, 32'hA0, 32'h0);
		repeat (1100) @(posedge i_clock);
		cmp(hi | lo, 32'h0);
		lock <= 1'h0;
		for (i = 0; i < 8; i++) begin
			apb(1'h1, `RXEI_IDX_FMT, i << 4);
			slave <= (i > 5);
			pulse(6'h01);
			repeat (1600) @(posedge i_clock);
			cpin(bcoe, i < 6);
			cmp(((i[0] && i > 4) ? lo : hi) >> sft[i] & 32'hFFFF, {16'h0, sl[23:8]});
			cmp(((i[0] && i > 4) ? hi : lo) >> sft[i] & 32'hFFFF, {16'h0, sr[23:8]});
		end
		apb(1'h1, `RXEI_IDX_FMT, 32'h40);
		slave <= 1'h0;
		serr <= 1'h1;
		sl <= 24'h0F0F0F;
		pulse(6'h01);
		serr <= 1'h0;
		repeat (1600) @(posedge i_clock);
		cmp(hi >> 16, 32'hA5C3);
		apb(1'h1, `RXEI_IDX_CLK, 32'h10);
		lock <= 1'h1;
		repeat (1600) @(posedge i_clock);
		cmp(hi >> 8, {8'h0, auxw});
		cpin(irqa | irqb, 1'h0);
		lock <= 1'h0;
		apb(1'h1, `RXEI_IDX_CLK, 32'h0);
		apb(1'h1, `RXEI_IDX_MASK_A, 32'hFF);
		par <= 1'h1;
		repeat (4) @(posedge i_clock);
		lock <= 1'h1;
		repeat (4) @(posedge i_clock);
		cpin(irqa, 1'h1);
		lock <= 1'h0;
		par <= 1'h0;
		cch <= 1'h1;
		pulse(6'h04);
		cch <= 1'h0;
		rdc(`RXEI_IDX_STAT0, 32'h8, 32'h8);
		cpin(irqb, 1'h1);
		pulse(6'h04);
		rdc(`RXEI_IDX_STAT0, 32'h8, 32'h0);
		nph <= 1'h1;
		pulse(6'h02);
		nph <= 1'h0;
		for (i = 1; i < 4095; i++) pulse(6'h02);
		rdc(`RXEI_IDX_STAT0, 32'h40, 32'h0);
		pulse(6'h02);
		rdc(`RXEI_IDX_STAT0, 32'h40, 32'h40);
		complete_run();
	end
endmodule // tb_top
